//--- pkg/pps_params.svh
// Purpose: constants for the pump prime and standby supervisor
// Assumes: 50 MHz clock, register port with one-cycle read latency
// Notes: offsets are word indices on the plain register port
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH
`define PPS_CLK_HZ 50000000
// Time base for the parameter timers: 1 ms tick
`define PPS_TICK_MS 1
`define PPS_TICK_CYC ((`PPS_CLK_HZ / 1000) * `PPS_TICK_MS)
// Register offsets
`define PPS_A_CTRL 4'h0
`define PPS_A_SRC 4'h1
`define PPS_A_PRIME 4'h2
`define PPS_A_BURST 4'h3
`define PPS_A_SBLVL 4'h4
`define PPS_A_SBDLY 4'h5
`define PPS_A_WAKE 4'h6
`define PPS_A_FILLT 4'h7
`define PPS_A_FILLS 4'h8
`define PPS_A_ACODE 4'h9
`define PPS_A_STDKEY 4'hA
`define PPS_A_ADVKEY 4'hB
`define PPS_A_STATUS 4'hC
`define PPS_A_FBMON 4'hD
// Field positions
`define PPS_B_RUN 0
`define PPS_B_TRIPRST 1
`define PPS_B_SENSE 2
// Reset values
`define PPS_R_STDKEY 16'h0065
`define PPS_R_ADVKEY 16'h00C9
`define PPS_R_SRC 16'h0000
// Codes
`define PPS_SRC_PID 2'h3
`define PPS_FB_AIN2 2'h0
`define PPS_SP_AIN1 2'h1
`define PPS_FMT_T420 2'h2
// Loss of a 4-20mA loop: below about 3 mA of 20 mA full scale
`define PPS_LOOP_LOST 16'h2666
`endif

//--- pkg/pps_pkg.sv
// Purpose: types for the pump prime and standby supervisor
// Assumes: nothing beyond SystemVerilog
// Notes: timing and offsets live in pps_params.svh
package pps_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FILL,
      ST_PRIME,
      ST_RUN,
      ST_SLEEP,
      ST_TRIP
   } pps_state_t;
   typedef enum logic [1:0] {
      LVL_BASIC,
      LVL_STD,
      LVL_ADV
   } pps_level_t;
endpackage

//--- hdl/pps_supervisor.sv
// Purpose: pipe prime, burst pipe, standby and soft fill supervision
// Assumes: analog and speed values already digitised on CLK
// Notes: loop arithmetic and motor control live elsewhere
//
// Our own choices: the plain strobed port and the placing of the registers.
`include "pps_params.svh"

module pps_supervisor import pps_pkg::*; #(
   parameter int TICK_CYC = `PPS_TICK_CYC
) (
   input wire logic CLK, // 50 MHz clock
   input wire logic NRST, // Async reset, active low
   input wire logic [3:0] ADDR, // Register index
   input wire logic [15:0] WDATA, // Write data
   input wire logic WR, // Write strobe
   input wire logic RD, // Read strobe
   input wire logic [7:0] WR_GROUP, // Parameter group of this write
   output logic [15:0] RDATA, // Read data, cycle after RD
   output logic WR_DENIED, // Write refused, pulse
   input wire logic [15:0] AIN1, // Analog input 1 value
   input wire logic [15:0] AIN2, // Analog input 2 value
   input wire logic [15:0] SPEED_IN, // Present output speed
   input wire logic [15:0] PID_DEMAND, // Loop output speed demand
   output logic [15:0] SETPOINT, // Selected set-point
   output logic [15:0] FEEDBACK, // Selected feedback
   output logic [15:0] ERROR_OUT, // Signed control error
   output logic [15:0] SPEED_CMD, // Speed command to motor
   output logic RUN_OUT, // Motor output enabled
   output logic LOW_PRESS_TRIP, // Low-pressure trip latched
   output logic LOOP_LOSS_TRIP, // 4-20mA signal loss trip
   output logic PRESS_WARN // Low-pressure warning
);

   //*******************************************
   // Parameter registers
   //*******************************************
   logic run_ff, sense_ff, trip_rst;
   logic [1:0] ctl_src_ff, fb_src_ff, sp_src_ff, ain2_fmt_ff;
   logic [15:0] prime_t_ff, burst_ff, sb_lvl_ff, sb_dly_ff, wake_ff;
   logic [15:0] fill_t_ff, fill_s_ff, acode_ff, stdkey_ff, advkey_ff;
   pps_level_t level;
   logic wr_ok;

   // Access level from the code compared to both keys
   always_comb begin
      if (acode_ff == advkey_ff) begin
         level = LVL_ADV;
      end else if (acode_ff == stdkey_ff) begin
         level = LVL_STD;
      end else begin
         level = LVL_BASIC;
      end
   end

   // Group 0 never writable bar the access code; group gating by level
   always_comb begin
      case (level)
         LVL_ADV: wr_ok = (WR_GROUP != 8'h00);
         LVL_STD: wr_ok = (WR_GROUP >= 8'h01 && WR_GROUP <= 8'h05)
            || WR_GROUP == 8'h08;
         default: wr_ok = (WR_GROUP == 8'h01);
      endcase
   end

   // Register writes; access code always writable to unlock
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         run_ff <= 1'b0;
         sense_ff <= 1'b0;
         ctl_src_ff <= 2'h0;
         {fb_src_ff, sp_src_ff, ain2_fmt_ff} <= 6'h00;
         prime_t_ff <= 16'h0000;
         burst_ff <= 16'h0000;
         sb_lvl_ff <= 16'h0000;
         sb_dly_ff <= 16'h0000;
         wake_ff <= 16'h0000;
         fill_t_ff <= 16'h0000;
         fill_s_ff <= 16'h0000;
         acode_ff <= 16'h0000;
         stdkey_ff <= `PPS_R_STDKEY;
         advkey_ff <= `PPS_R_ADVKEY;
      end else if (WR && (wr_ok || ADDR == `PPS_A_ACODE)) begin
         case (ADDR)
            `PPS_A_CTRL: begin
               run_ff <= WDATA[`PPS_B_RUN];
               sense_ff <= WDATA[`PPS_B_SENSE];
            end
            `PPS_A_SRC: begin
               ctl_src_ff <= WDATA[1:0];
               fb_src_ff <= WDATA[3:2];
               sp_src_ff <= WDATA[5:4];
               ain2_fmt_ff <= WDATA[7:6];
            end
            `PPS_A_PRIME: prime_t_ff <= WDATA;
            `PPS_A_BURST: burst_ff <= WDATA;
            `PPS_A_SBLVL: sb_lvl_ff <= WDATA;
            `PPS_A_SBDLY: sb_dly_ff <= WDATA;
            `PPS_A_WAKE: wake_ff <= WDATA;
            `PPS_A_FILLT: fill_t_ff <= WDATA;
            `PPS_A_FILLS: fill_s_ff <= WDATA;
            `PPS_A_ACODE: acode_ff <= WDATA;
            `PPS_A_STDKEY: stdkey_ff <= WDATA;
            `PPS_A_ADVKEY: advkey_ff <= WDATA;
            default: ;
         endcase
      end
   end

   // Trip reset is a self-clearing command bit
   assign trip_rst = WR && wr_ok && ADDR == `PPS_A_CTRL
      && WDATA[`PPS_B_TRIPRST];

   // Refused writes reported as a pulse
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         WR_DENIED <= 1'b0;
      end else begin
         WR_DENIED <= WR && !wr_ok && ADDR != `PPS_A_ACODE;
      end
   end

   //*******************************************
   // Source selection
   //*******************************************
   logic pid_mode;
   logic [16:0] err_wide;
   logic [15:0] err_mag;
   assign pid_mode = (ctl_src_ff == `PPS_SRC_PID);

   // Selected values registered; inputs already on CLK domain
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         FEEDBACK <= 16'h0000;
         SETPOINT <= 16'h0000;
      end else begin
         FEEDBACK <= (fb_src_ff == `PPS_FB_AIN2) ? AIN2 : AIN1;
         SETPOINT <= (sp_src_ff == `PPS_SP_AIN1) ? AIN1 : AIN2;
      end
   end

   // Error sign follows sense so demand rises as feedback falls in direct sense, as it rises in inverse
   always_comb begin
      if (sense_ff) begin
         err_wide = {1'b0, FEEDBACK} - {1'b0, SETPOINT};
      end else begin
         err_wide = {1'b0, SETPOINT} - {1'b0, FEEDBACK};
      end
      err_mag = err_wide[16] ? 16'(-err_wide) : err_wide[15:0];
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ERROR_OUT <= 16'h0000;
      end else begin
         ERROR_OUT <= err_wide[15:0];
      end
   end

   //*******************************************
   // Millisecond tick and timers
   //*******************************************
   logic [15:0] tick_cnt_ff;
   logic tick;
   logic [15:0] tmr_ff, sb_tmr_ff;
   pps_state_t st_ff, nxt_st;
   logic fb_ok, pid_prev_ff, run_prev_ff, start_evt, wake_evt;
   logic sb_elapsed, tmr_done;
   assign tick = (tick_cnt_ff == 16'(TICK_CYC - 1));

   // Shared time base keeps timers small; 1 ms resolution
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tick_cnt_ff <= 16'h0000;
      end else begin
         tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
      end
   end

   // Prime condition per control sense
   assign fb_ok = sense_ff ? (FEEDBACK >= burst_ff)
                           : (FEEDBACK <= burst_ff);

   // Start when enabled in loop mode or switched into it
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pid_prev_ff <= 1'b0;
         run_prev_ff <= 1'b0;
      end else begin
         pid_prev_ff <= pid_mode;
         run_prev_ff <= run_ff;
      end
   end
   assign start_evt = run_ff && pid_mode
      && (!run_prev_ff || !pid_prev_ff);

   // Standby timer counts ms while speed is below level
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         sb_tmr_ff <= 16'h0000;
      end else if (st_ff != ST_RUN || SPEED_IN >= sb_lvl_ff) begin
         sb_tmr_ff <= 16'h0000;
      end else if (tick && sb_tmr_ff != 16'hFFFF) begin
         sb_tmr_ff <= sb_tmr_ff + 16'h0001;
      end
   end
   assign sb_elapsed = (sb_dly_ff != 16'h0000)
      && (sb_tmr_ff > sb_dly_ff);
   assign wake_evt = (st_ff == ST_SLEEP) && (err_mag > wake_ff);

   //*******************************************
   // Sequence state machine
   //*******************************************
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: begin
            if (start_evt) begin
               nxt_st = (fill_t_ff != 16'h0000) ? ST_FILL
                  : (prime_t_ff != 16'h0000) ? ST_PRIME : ST_RUN;
            end
         end
         ST_FILL: begin
            if (tmr_done) begin
               nxt_st = (prime_t_ff != 16'h0000) ? ST_PRIME : ST_RUN;
            end
         end
         ST_PRIME: begin
            if (fb_ok) begin
               nxt_st = ST_RUN;
            end else if (tmr_done) begin
               nxt_st = ST_TRIP;
            end
         end
         ST_RUN: begin
            if (prime_t_ff != 16'h0000 && !fb_ok) begin
               nxt_st = ST_TRIP;
            end else if (sb_elapsed) begin
               nxt_st = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wake_evt) begin
               nxt_st = (fill_t_ff != 16'h0000) ? ST_FILL : ST_RUN;
            end
         end
         ST_TRIP: begin
            if (trip_rst) begin
               nxt_st = ST_IDLE;
            end
         end
         default: nxt_st = ST_IDLE;
      endcase
      // Leaving loop mode or enable drops supervision, except a trip
      if (st_ff != ST_TRIP && (!run_ff || !pid_mode)) begin
         nxt_st = ST_IDLE;
      end
      if (LOOP_LOSS_TRIP && st_ff != ST_TRIP) begin
         nxt_st = ST_IDLE;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         st_ff <= ST_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Phase timer restarts on each state change
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tmr_ff <= 16'h0000;
      end else if (nxt_st != st_ff) begin
         tmr_ff <= 16'h0000;
      end else if (tick && !tmr_done) begin
         tmr_ff <= tmr_ff + 16'h0001;
      end
   end
   assign tmr_done = (st_ff == ST_FILL) ? (tmr_ff >= fill_t_ff)
                                        : (tmr_ff >= prime_t_ff);

   //*******************************************
   // Trips and outputs
   //*******************************************
   logic loss;
   assign loss = (ain2_fmt_ff == `PPS_FMT_T420) && (AIN2 < `PPS_LOOP_LOST);

   // Loss trip sticky until trip reset; set wins over reset
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         LOOP_LOSS_TRIP <= 1'b0;
      end else if (loss) begin
         LOOP_LOSS_TRIP <= 1'b1;
      end else if (trip_rst) begin
         LOOP_LOSS_TRIP <= 1'b0;
      end
   end

   // Outputs registered from the next state
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         LOW_PRESS_TRIP <= 1'b0;
         RUN_OUT <= 1'b0;
         SPEED_CMD <= 16'h0000;
         PRESS_WARN <= 1'b0;
      end else begin
         LOW_PRESS_TRIP <= (nxt_st == ST_TRIP);
         RUN_OUT <= (nxt_st == ST_FILL || nxt_st == ST_PRIME
            || nxt_st == ST_RUN);
         SPEED_CMD <= (nxt_st == ST_FILL) ? fill_s_ff
            : (nxt_st == ST_PRIME || nxt_st == ST_RUN) ? PID_DEMAND
            : 16'h0000;
         PRESS_WARN <= (nxt_st == ST_RUN) && !fb_ok;
      end
   end

   //*******************************************
   // Read port, data one cycle after strobe
   //*******************************************
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         RDATA <= 16'h0000;
      end else if (RD) begin
         case (ADDR)
            `PPS_A_CTRL: RDATA <= {13'h0000, sense_ff, 1'b0, run_ff};
            `PPS_A_SRC: RDATA <= {8'h00, ain2_fmt_ff, sp_src_ff,
               fb_src_ff, ctl_src_ff};
            `PPS_A_PRIME: RDATA <= prime_t_ff;
            `PPS_A_BURST: RDATA <= burst_ff;
            `PPS_A_SBLVL: RDATA <= sb_lvl_ff;
            `PPS_A_SBDLY: RDATA <= sb_dly_ff;
            `PPS_A_WAKE: RDATA <= wake_ff;
            `PPS_A_FILLT: RDATA <= fill_t_ff;
            `PPS_A_FILLS: RDATA <= fill_s_ff;
            `PPS_A_ACODE: RDATA <= acode_ff;
            `PPS_A_STATUS: RDATA <= {8'h00, LOOP_LOSS_TRIP, LOW_PRESS_TRIP,
               level, 1'b0, st_ff};
            `PPS_A_FBMON: RDATA <= FEEDBACK;
            default: RDATA <= 16'h0000;
         endcase
      end else begin
         RDATA <= 16'h0000;
      end
   end
endmodule

//--- tb/pps_plant.sv
// Purpose: plant model, pump pipe with a sensor on analog input 2
// Assumes: pressure slews one step a cycle toward a target
// Notes: a broken sensor loop reads as zero current
module pps_plant (
   input wire logic clk, // Clock
   input wire logic nrst, // Reset, active low
   input wire logic [15:0] tgt, // Pressure the pipe settles to
   input wire logic lost, // Sensor wire broken
   input wire logic [15:0] speed_cmd, // Drive speed command
   output logic [15:0] ain2, // Sensor reading
   output logic [15:0] speed_in // Measured motor speed
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************************
   // Pipe and motor
   // ************************
   logic [15:0] p_ff;
   logic [15:0] spd_ff;
   // Slew so that priming takes real time, never a jump
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) p_ff <= 16'h0000;
      else if (p_ff < tgt) p_ff <= p_ff + 16'h0400;
      else if (p_ff > tgt) p_ff <= p_ff - 16'h0400;
   end
   // Motor lags the command by a cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) spd_ff <= 16'h0000;
      else spd_ff <= speed_cmd;
   end
   // Lost loop gives no current at all
   assign ain2 = lost ? 16'h0000 : p_ff;
   assign speed_in = spd_ff;
endmodule

//--- tb/pps_monitor.sv
// Purpose: port assertions for the prime and standby supervisor
// Assumes: one clock domain, async active-low reset
// Notes: bound to every supervisor instance
module pps_monitor (
   input wire logic CLK, // Clock
   input wire logic NRST, // Reset, active low
   input wire logic [3:0] ADDR, // Register index
   input wire logic WR, // Write strobe
   input wire logic [7:0] WR_GROUP, // Group of the write
   input wire logic WR_DENIED, // Refusal pulse
   input wire logic [15:0] SPEED_CMD, // Speed command
   input wire logic RUN_OUT, // Motor enabled
   input wire logic LOW_PRESS_TRIP, // Pressure trip
   input wire logic LOOP_LOSS_TRIP, // Loop loss trip
   input wire logic PRESS_WARN // Pressure warning
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************************
   // Assertions
   // ************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   // Only a write can clear a pressure trip
   sequence s_trip_quiet;
      LOW_PRESS_TRIP && !WR;
   endsequence
   // Monitoring group never takes writes other than to the access code
   sequence s_grp0_wr;
      WR && WR_GROUP == 8'h00 && ADDR != 4'h9;
   endsequence
   chk_trip_stops: assert property (LOW_PRESS_TRIP |-> !RUN_OUT)
      else $error("pump enabled while tripped");
   chk_trip_latch: assert property (
      s_trip_quiet |=> LOW_PRESS_TRIP)
      else $error("pressure trip dropped without reset");
   chk_trip_cause: assert property (
      $rose(LOW_PRESS_TRIP) |-> $past(RUN_OUT))
      else $error("trip raised while pump idle");
   chk_warn_run: assert property (
      PRESS_WARN |-> RUN_OUT && !LOW_PRESS_TRIP)
      else $error("warning outside running");
   chk_grp0_deny: assert property (s_grp0_wr |=> WR_DENIED)
      else $error("monitor group write taken");
   chk_grp1_open: assert property (
      WR && WR_GROUP == 8'h01 |=> !WR_DENIED)
      else $error("basic group write refused");
   chk_deny_cause: assert property (WR_DENIED |-> $past(WR))
      else $error("refusal without a write");
   chk_stop_speed: assert property (
      !RUN_OUT |-> SPEED_CMD == 16'h0000)
      else $error("speed commanded while stopped");
   chk_loss_stop: assert property (
      LOOP_LOSS_TRIP [*2] |-> !RUN_OUT)
      else $error("pump enabled after loop loss");
endmodule
bind pps_supervisor pps_monitor i_mon (.CLK, .NRST, .ADDR, .WR, .WR_GROUP,
   .WR_DENIED, .SPEED_CMD, .RUN_OUT, .LOW_PRESS_TRIP, .LOOP_LOSS_TRIP,
   .PRESS_WARN);

//--- tb/tb_top.sv
// Purpose: self-checking bench for the prime and standby supervisor
// Assumes: TICK_CYC of 4, so one ms is four cycles
// Notes: registers reached through one-cycle strobes
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, lost = 1'b0, den;
   logic [3:0] ADDR = 4'h0;
   logic [7:0] WR_GROUP = 8'h00;
   logic [15:0] WDATA = 16'h0000, AIN1 = 16'h1000, PID_DEMAND = 16'h0800;
   logic [15:0] tgt = 16'h1000, RDATA, SETPOINT, FEEDBACK, ERROR_OUT, d;
   logic [15:0] SPEED_CMD, AIN2, SPEED_IN;
   logic WR_DENIED, RUN_OUT, LOW_PRESS_TRIP, LOOP_LOSS_TRIP, PRESS_WARN;
   int n_mismatch = 0, total_checks = 0, cyc = 0, k;
   pps_supervisor #(.TICK_CYC(4)) i_dut (.CLK, .NRST, .ADDR, .WDATA, .WR,
      .RD, .WR_GROUP, .RDATA, .WR_DENIED, .AIN1, .AIN2, .SPEED_IN,
      .PID_DEMAND, .SETPOINT, .FEEDBACK, .ERROR_OUT, .SPEED_CMD, .RUN_OUT,
      .LOW_PRESS_TRIP, .LOOP_LOSS_TRIP, .PRESS_WARN);
   pps_plant i_plant (.clk(CLK), .nrst(NRST), .tgt, .lost,
      .speed_cmd(SPEED_CMD), .ain2(AIN2), .speed_in(SPEED_IN));
   // ************************
   // Clock, watchdog, tasks
   // ************************
   // 50 MHz
   always #10 CLK = ~CLK;
   // Whole run needs about 500 cycles
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cf(input string nm, input logic e, g);
      chk(nm, {15'h0000, e}, {15'h0000, g});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   // Refusal pulse sampled in the cycle after the write
   task automatic wr(input logic [3:0] a, input logic [15:0] v,
      input logic [7:0] g);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= v;
      WR_GROUP <= g;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      #1 den = WR_DENIED;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask
   task automatic wait_run(input logic v);
      k = 0;
      while (RUN_OUT !== v && k < 100) begin
         wt(1);
         k++;
      end
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge CLK);
      NRST <= 1'b1;
      rd(4'hC);
      chk("status", 16'h0000, d);
      wr(4'h2, 16'h000A, 8'h03);
      cf("basic g3", 1'b1, den);
      wr(4'h9, 16'h0065, 8'h01);
      wr(4'h7, 16'h0002, 8'h06);
      cf("std g6", 1'b1, den);
      wr(4'h2, 16'h000A, 8'h03);
      cf("std g3", 1'b0, den);
      wr(4'h3, 16'h4000, 8'h08);
      cf("std g8", 1'b0, den);
      wr(4'h9, 16'h00C9, 8'h01);
      rd(4'hC);
      chk("level", 16'h0020, d);
      wr(4'h7, 16'h0002, 8'h06);
      cf("adv g6", 1'b0, den);
      wr(4'hD, 16'h1234, 8'h00);
      cf("g0", 1'b1, den);
      rd(4'hF);
      chk("unmapped", 16'h0000, d);
      $display("test access done");
      wr(4'h8, 16'h0300, 8'h02);
      wr(4'h1, 16'h0013, 8'h03);
      wr(4'h0, 16'h0001, 8'h01);
      // Sequence starts one edge after the enable lands
      wt(1);
      chk("fill", 16'h0300, SPEED_CMD);
      wt(16);
      chk("loop", 16'h0800, SPEED_CMD);
      wt(60);
      cf("primed", 1'b0, LOW_PRESS_TRIP);
      @(posedge CLK) tgt <= 16'h6000;
      wt(30);
      cf("burst", 1'b1, LOW_PRESS_TRIP);
      wr(4'h0, 16'h0000, 8'h01);
      cf("latched", 1'b1, LOW_PRESS_TRIP);
      wr(4'h0, 16'h0002, 8'h01);
      wt(1);
      cf("cleared", 1'b0, LOW_PRESS_TRIP);
      $display("test prime direct done");
      // Inverse sense with low pressure: prime must time out
      @(posedge CLK) tgt <= 16'h1000;
      wr(4'h7, 16'h0000, 8'h06);
      wt(30);
      wr(4'h0, 16'h0005, 8'h01);
      k = 0;
      while (LOW_PRESS_TRIP !== 1'b1 && k < 80) begin
         cf("warn", 1'b0, PRESS_WARN);
         wt(1);
         k++;
      end
      cf("timeout", 1'b1, k >= 36 && k <= 48);
      wr(4'h0, 16'h0002, 8'h01);
      wr(4'h2, 16'h0000, 8'h03);
      @(posedge CLK) tgt <= 16'h6000;
      wr(4'h0, 16'h0001, 8'h01);
      wt(40);
      cf("prime off", 1'b0, LOW_PRESS_TRIP);
      cf("warn run", 1'b1, PRESS_WARN);
      chk("fb", 16'h6000, FEEDBACK);
      chk("sp", 16'h1000, SETPOINT);
      chk("err", 16'hB000, ERROR_OUT);
      wr(4'h0, 16'h0005, 8'h01);
      wt(2);
      chk("inv err", 16'h5000, ERROR_OUT);
      wr(4'h0, 16'h0000, 8'h01);
      wr(4'h2, 16'h000A, 8'h03);
      wr(4'h1, 16'h0010, 8'h03);
      wr(4'h0, 16'h0001, 8'h01);
      wt(60);
      cf("src0 run", 1'b0, RUN_OUT);
      cf("src0 trip", 1'b0, LOW_PRESS_TRIP);
      // Switching into loop mode while enabled starts supervision
      wr(4'h1, 16'h0013, 8'h03);
      wt(1);
      cf("switch in", 1'b1, RUN_OUT);
      $display("test prime modes done");
      wr(4'h0, 16'h0000, 8'h01);
      wr(4'h1, 16'h0013, 8'h03);
      wr(4'h2, 16'h0000, 8'h03);
      wr(4'h4, 16'h0200, 8'h03);
      wr(4'h5, 16'h0003, 8'h02);
      wr(4'h6, 16'h0400, 8'h03);
      @(posedge CLK) PID_DEMAND <= 16'h0100;
      tgt <= 16'h1000;
      wt(30);
      wr(4'h0, 16'h0001, 8'h01);
      wt(1);
      chk("no fill", 16'h0100, SPEED_CMD);
      wait_run(1'b0);
      cf("standby", 1'b1, k >= 12 && k <= 24);
      wr(4'h7, 16'h0002, 8'h06);
      @(posedge CLK) AIN1 <= 16'h3000;
      wt(0);
      wait_run(1'b1);
      cf("wake", 1'b1, k <= 4);
      chk("wake fill", 16'h0300, SPEED_CMD);
      wr(4'h5, 16'h0000, 8'h02);
      k = 0;
      repeat (60) begin
         wt(1);
         if (RUN_OUT !== 1'b1) k++;
      end
      cf("no standby", 1'b1, k == 0);
      $display("test standby done");
      // Sensor loop sound first, then broken
      @(posedge CLK) tgt <= 16'h3000;
      wt(10);
      wr(4'h1, 16'h0093, 8'h02);
      cf("loop ok", 1'b0, LOOP_LOSS_TRIP);
      @(posedge CLK) lost <= 1'b1;
      wt(4);
      cf("loss", 1'b1, LOOP_LOSS_TRIP);
      cf("loss stop", 1'b0, RUN_OUT);
      @(posedge CLK) lost <= 1'b0;
      wr(4'h0, 16'h0002, 8'h01);
      wt(1);
      cf("loss clr", 1'b0, LOOP_LOSS_TRIP);
      $display("test loop loss done");
      close_out();
   end
endmodule
